// File: src/lcd_drv_core.sv
// Logic core of an 80-channel LCD driver, segment or common role.
// Assumes an AXI4-Lite master on aclk and pins asynchronous to aclk.
//
// Functional notes
// - Role select low gives segment driver, high gives common driver.
// - Role and application select pick parallel, serial, single or dual.
// - Serial segment needs 80 shift pulses, parallel segment needs 20.
// - Parallel segment shifts one 4-bit unit per pulse from all pins.
// - Serial segment takes data from the first pin only.
// - Segment shift pulses are ignored while the cascade input is high.
// - Segment shift register is copied to the latch on line clock fall.
// - Line clock high restarts the segment power-down logic.
// - High cascade input disables the driver; data cannot change outputs.
// - Each chained chip enables the next through its output once it is full.
// - Direction bit picks shift direction and segment enable pin roles.
// - Common mode shifts on the line clock, ignoring the data clock.
// - Single common chain shifts one bit from entry pin to far pin.
// - Dual common mode splits the register into two independent halves.
// - Dual chains enter at middle pin and at direction-chosen edge pin.
// - Display off low forces every output to the top bias level.
// - Otherwise alternation and latched bit select the level per role.
// - Common mode uses no power-down; enable pins are left undriven.
// - Unused data pins are ignored in single common and serial modes.
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "lcd_drv_regs.svh"
module lcd_drv_core (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic line_latch_clock,
	input wire logic data_shift_clock,
	input wire logic alternation,
	input wire logic data_pin_first,
	input wire logic data_pin_left_i,
	output logic data_pin_left_o,
	output logic data_pin_left_oe,
	input wire logic data_pin_middle,
	input wire logic data_pin_right_i,
	output logic data_pin_right_o,
	output logic data_pin_right_oe,
	input wire logic left_cascade_enable_i,
	output logic left_cascade_enable_o,
	output logic left_cascade_enable_oe,
	input wire logic right_cascade_enable_i,
	output logic right_cascade_enable_o,
	output logic right_cascade_enable_oe,
	output logic [2*`LCD_CHANNELS-1:0] drive_outputs
);

	// Level code for one channel from role, alternation and latched bit
	function automatic lcd_pkg::lcd_level_t level_code(
		input logic disp_n,
		input logic com_role,
		input logic alt,
		input logic bit_on
	);
		lcd_pkg::lcd_level_t code;
		code = lcd_pkg::LCD_LVL_TOP;
		if (!disp_n) begin
			code = lcd_pkg::LCD_LVL_TOP;
		end else begin
			case ({alt, bit_on})
				2'b00: code = lcd_pkg::LCD_LVL_TOP_MID;
				2'b01: code = com_role ? lcd_pkg::LCD_LVL_BOT
					: lcd_pkg::LCD_LVL_TOP;
				2'b10: code = lcd_pkg::LCD_LVL_BOT_MID;
				2'b11: code = com_role ? lcd_pkg::LCD_LVL_TOP
					: lcd_pkg::LCD_LVL_BOT;
				default: code = lcd_pkg::LCD_LVL_TOP;
			endcase
		end
		return code;
	endfunction

	// Synchronised pin inputs
	logic [8:0] pin_level;
	logic [8:0] pin_rise;
	logic [8:0] pin_fall;

	lcd_sync #(
		.W(9)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({right_cascade_enable_i, left_cascade_enable_i,
			data_pin_right_i, data_pin_middle, data_pin_left_i,
			data_pin_first, alternation, data_shift_clock,
			line_latch_clock}),
		.level(pin_level),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	logic llck;
	logic llck_fall;
	logic dsck_rise;
	logic alt_s;
	logic [3:0] data_s;
	logic en_left_s;
	logic en_right_s;

	assign llck = pin_level[0];
	assign llck_fall = pin_fall[0];
	assign dsck_rise = pin_rise[1];
	assign alt_s = pin_level[2];
	assign data_s = pin_level[6:3];
	assign en_left_s = pin_level[7];
	assign en_right_s = pin_level[8];

	// Control register and decoded mode
	logic [3:0] ctrl;
	logic [3:0] next_ctrl;
	logic com_role;
	logic dir_rl;
	lcd_pkg::lcd_mode_t mode;

	assign com_role = ctrl[`LCD_CTRL_ROLE];
	assign dir_rl = ctrl[`LCD_CTRL_DIR];
	assign mode = lcd_pkg::lcd_mode_t'({ctrl[`LCD_CTRL_ROLE],
		ctrl[`LCD_CTRL_APP]});

	// Display state
	logic [`LCD_CHANNELS-1:0] line;
	logic [`LCD_CHANNELS-1:0] next_line;
	logic [`LCD_CHANNELS-1:0] shreg;
	logic [`LCD_CHANNELS-1:0] next_shreg;
	logic [6:0] count;
	logic [6:0] next_count;
	logic full;
	logic next_full;
	logic enabled;

	// Enable input is the pin opposite to the one that passes enable on
	assign enabled = !com_role && !(dir_rl ? en_left_s
		: en_right_s);

	// Shift, latch and power-down state
	always_comb begin
		logic [6:0] limit;
		logic [3:0] nib;
		limit = (mode == lcd_pkg::LCD_MODE_SEG_SER) ? `LCD_SERIAL_PULSES
			: `LCD_PARALLEL_PULSES;
		nib = {data_s[3], data_s[2], data_s[1], data_s[0]};
		next_line = line;
		next_shreg = shreg;
		next_count = count;
		next_full = full;
		if (!com_role) begin
			if (llck) begin
				// Restart power-down while line clock is high
				next_count = 7'h00;
				next_full = 1'b0;
			end else if (dsck_rise && enabled && !full) begin
				if (mode == lcd_pkg::LCD_MODE_SEG_SER) begin
					// Only the first pin carries data
					next_shreg = dir_rl ? {data_s[0],
						shreg[`LCD_CHANNELS-1:1]}
						: {shreg[`LCD_CHANNELS-2:0],
						data_s[0]};
				end else begin
					next_shreg = dir_rl ? {nib,
						shreg[`LCD_CHANNELS-1:`LCD_NIBBLE]}
						: {shreg[`LCD_CHANNELS-`LCD_NIBBLE-1:0],
						nib};
				end
				next_count = count + 7'h01;
				next_full = (count + 7'h01) == limit;
			end
			if (llck_fall && enabled) begin
				next_line = shreg;
			end
		end else if (llck_fall) begin
			// Common role shifts on the line clock only
			case (mode)
				lcd_pkg::LCD_MODE_COM_SINGLE:
					next_line = dir_rl ? {data_s[3],
						line[`LCD_CHANNELS-1:1]}
						: {line[`LCD_CHANNELS-2:0],
						data_s[1]};
				lcd_pkg::LCD_MODE_COM_DUAL:
					next_line = dir_rl ? {data_s[3],
						line[`LCD_CHANNELS-1:`LCD_HALF+1],
						data_s[2], line[`LCD_HALF-1:1]}
						: {line[`LCD_CHANNELS-2:`LCD_HALF],
						data_s[2], line[`LCD_HALF-2:0],
						data_s[1]};
				default: next_line = line;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line <= '0;
			shreg <= '0;
			count <= 7'h00;
			full <= 1'b0;
		end else begin
			line <= next_line;
			shreg <= next_shreg;
			count <= next_count;
			full <= next_full;
		end
	end

	// Pin drive and per-channel level codes
	logic [2*`LCD_CHANNELS-1:0] next_drive;
	logic next_left_o;
	logic next_left_oe;
	logic next_right_o;
	logic next_right_oe;
	logic next_enl_o;
	logic next_enl_oe;
	logic next_enr_o;
	logic next_enr_oe;

	always_comb begin
		for (int i = 0; i < `LCD_CHANNELS; i++) begin
			next_drive[2*i +: 2] = level_code(ctrl[`LCD_CTRL_DISP],
				com_role, alt_s, line[i]);
		end
		// Far edge pin carries the common scan bit onward
		next_left_o = line[0];
		next_right_o = line[`LCD_CHANNELS-1];
		next_left_oe = com_role && dir_rl;
		next_right_oe = com_role && !dir_rl;
		// Filled chip passes an active-low enable to its neighbour
		next_enl_o = !full;
		next_enr_o = !full;
		next_enl_oe = !com_role && !dir_rl;
		next_enr_oe = !com_role && dir_rl;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drive_outputs <= '0;
			data_pin_left_o <= 1'b0;
			data_pin_left_oe <= 1'b0;
			data_pin_right_o <= 1'b0;
			data_pin_right_oe <= 1'b0;
			left_cascade_enable_o <= 1'b1;
			left_cascade_enable_oe <= 1'b0;
			right_cascade_enable_o <= 1'b1;
			right_cascade_enable_oe <= 1'b0;
		end else begin
			drive_outputs <= next_drive;
			data_pin_left_o <= next_left_o;
			data_pin_left_oe <= next_left_oe;
			data_pin_right_o <= next_right_o;
			data_pin_right_oe <= next_right_oe;
			left_cascade_enable_o <= next_enl_o;
			left_cascade_enable_oe <= next_enl_oe;
			right_cascade_enable_o <= next_enr_o;
			right_cascade_enable_oe <= next_enr_oe;
		end
	end

	// AXI4-Lite write channel: address and data taken in either order
	logic next_awready;
	logic next_wready;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic [7:0] waddr;
	logic [7:0] next_waddr;
	logic [31:0] wdata;
	logic [31:0] next_wdata;
	logic [3:0] wstrb;
	logic [3:0] next_wstrb;

	always_comb begin
		next_awready = s_axi_awready;
		next_wready = s_axi_wready;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_waddr = waddr;
		next_wdata = wdata;
		next_wstrb = wstrb;
		next_ctrl = ctrl;
		if (s_axi_awready && s_axi_awvalid) begin
			next_awready = 1'b0;
			next_waddr = s_axi_awaddr;
		end
		if (s_axi_wready && s_axi_wvalid) begin
			next_wready = 1'b0;
			next_wdata = s_axi_wdata;
			next_wstrb = s_axi_wstrb;
		end
		// Commit once both halves are held; bvalid blocks a repeat
		if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
			next_bvalid = 1'b1;
			if (waddr[7:2] == 6'(`LCD_OFS_CTRL >> 2)) begin
				next_bresp = `LCD_RESP_OKAY;
				if (wstrb[0]) begin
					next_ctrl = wdata[3:0];
				end
			end else if (waddr[7:2] <= 6'(`LCD_OFS_SHIFT2 >> 2)) begin
				next_bresp = `LCD_RESP_SLVERR;
			end else begin
				next_bresp = `LCD_RESP_DECERR;
			end
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
			next_awready = 1'b1;
			next_wready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LCD_RESP_OKAY;
			waddr <= 8'h00;
			wdata <= 32'h0000_0000;
			wstrb <= 4'h0;
			ctrl <= `LCD_CTRL_RESET;
		end else begin
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			waddr <= next_waddr;
			wdata <= next_wdata;
			wstrb <= next_wstrb;
			ctrl <= next_ctrl;
		end
	end

	// AXI4-Lite read channel: answer one cycle after the address
	logic next_arready;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	always_comb begin
		next_arready = s_axi_arready;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_arready && s_axi_arvalid) begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rresp = `LCD_RESP_OKAY;
			case (s_axi_araddr[7:2])
				6'(`LCD_OFS_CTRL >> 2):
					next_rdata = {28'h000_0000, ctrl};
				6'(`LCD_OFS_STATUS >> 2): begin
					next_rdata = 32'h0000_0000;
					next_rdata[`LCD_STAT_FULL] = full;
					next_rdata[`LCD_STAT_EN] = enabled;
					next_rdata[`LCD_STAT_CNT_LSB +: 7] = count;
				end
				6'(`LCD_OFS_LINE0 >> 2): next_rdata = line[31:0];
				6'(`LCD_OFS_LINE1 >> 2): next_rdata = line[63:32];
				6'(`LCD_OFS_LINE2 >> 2):
					next_rdata = {16'h0000, line[79:64]};
				6'(`LCD_OFS_SHIFT0 >> 2): next_rdata = shreg[31:0];
				6'(`LCD_OFS_SHIFT1 >> 2): next_rdata = shreg[63:32];
				6'(`LCD_OFS_SHIFT2 >> 2):
					next_rdata = {16'h0000, shreg[79:64]};
				default: begin
					// Unmapped words read as zero with a decode error
					next_rdata = 32'h0000_0000;
					next_rresp = `LCD_RESP_DECERR;
				end
			endcase
		end
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `LCD_RESP_OKAY;
		end else begin
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

endmodule

// File: src/lcd_drv_regs.svh
// Constants of the dot-matrix LCD com/seg driver core: register map,
// field positions, reset values and shift counts.
// Assumes inclusion by bare name from the design and test files.
`ifndef LCD_DRV_REGS_SVH
`define LCD_DRV_REGS_SVH

// Geometry of the output line
`define LCD_CHANNELS 80
`define LCD_HALF 40
`define LCD_NIBBLE 4
`define LCD_SERIAL_PULSES 7'h50
`define LCD_PARALLEL_PULSES 7'h14

// Register byte offsets
`define LCD_OFS_CTRL 8'h00
`define LCD_OFS_STATUS 8'h04
`define LCD_OFS_LINE0 8'h08
`define LCD_OFS_LINE1 8'h0C
`define LCD_OFS_LINE2 8'h10
`define LCD_OFS_SHIFT0 8'h14
`define LCD_OFS_SHIFT1 8'h18
`define LCD_OFS_SHIFT2 8'h1C

// Control register fields
`define LCD_CTRL_ROLE 0
`define LCD_CTRL_APP 1
`define LCD_CTRL_DIR 2
`define LCD_CTRL_DISP 3
`define LCD_CTRL_RESET 4'h0

// Status register fields
`define LCD_STAT_FULL 0
`define LCD_STAT_EN 1
`define LCD_STAT_CNT_LSB 8

// AXI responses
`define LCD_RESP_OKAY 2'h0
`define LCD_RESP_SLVERR 2'h2
`define LCD_RESP_DECERR 2'h3

`endif

// File: src/lcd_pkg.sv
// Types shared by the LCD com/seg driver core.
// Assumes nothing of its surroundings.
package lcd_pkg;

	// Drive level select per output channel
	typedef enum logic [1:0] {
		LCD_LVL_TOP = 2'b00,
		LCD_LVL_TOP_MID = 2'b01,
		LCD_LVL_BOT_MID = 2'b10,
		LCD_LVL_BOT = 2'b11
	} lcd_level_t;

	// Operating mode from role and application select
	typedef enum logic [1:0] {
		LCD_MODE_SEG_PAR = 2'b00,
		LCD_MODE_SEG_SER = 2'b01,
		LCD_MODE_COM_SINGLE = 2'b10,
		LCD_MODE_COM_DUAL = 2'b11
	} lcd_mode_t;

endpackage

// File: src/lcd_sync.sv
// Two-stage synchroniser with edge detection for pin inputs.
// Assumes inputs asynchronous to aclk; edges are one-cycle pulses.
`timescale 1ns/10ps
module lcd_sync #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);

	logic [W-1:0] meta;
	logic [W-1:0] stable;
	logic [W-1:0] prev;

	// First stage feeds only the second stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= '0;
			stable <= '0;
			prev <= '0;
		end else begin
			meta <= async_in;
			stable <= meta;
			prev <= stable;
		end
	end

	// Edges are taken between settled stages only
	assign level = stable;
	assign rise = stable & ~prev;
	assign fall = ~stable & prev;

endmodule

// File: test/lcd_ctrl_model.sv
// Timing controller model: line clock, shift clock and data pins.
// Assumes the bench calls its task one pulse at a time.
`timescale 1ns/10ps
module lcd_ctrl_model (
	output logic line_latch_clock,
	output logic data_shift_clock,
	output logic [3:0] pd
);
	// Both clocks stand low between frames
	initial begin
		line_latch_clock = 1'b0;
		data_shift_clock = 1'b0;
		pd = 4'hF;
	end
	// One 200 ns pulse in a 400 ns slot; data is held from well before the rise until well
	// after the fall, since common mode samples it at the falling edge.
	// No pin moves on an aclk edge, so the synchroniser sees no race.
	task automatic pulse(input logic line, input logic [3:0] v);
		#13;
		pd = v;
		#97;
		line_latch_clock = line;
		data_shift_clock = !line;
		#200;
		line_latch_clock = 1'b0;
		data_shift_clock = 1'b0;
		#80;
		pd = ~pd;
		#10;
	endtask
endmodule

// File: test/lcd_drv_core_asserts.sv
// Concurrent checks on the register port and pin roles of the core.
// Assumes control writes offer address and data in the same cycle.
`timescale 1ns/10ps
`include "lcd_drv_regs.svh"
module lcd_drv_core_asserts (
	input logic aclk,
	input logic aresetn,
	input logic [7:0] s_axi_awaddr,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic [3:0] s_axi_wstrb,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [7:0] s_axi_araddr,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0] s_axi_rresp,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic data_pin_left_oe,
	input logic data_pin_right_oe,
	input logic left_cascade_enable_oe,
	input logic right_cascade_enable_oe,
	input logic [2*`LCD_CHANNELS-1:0] drive_outputs
);
	logic aw_t, w_t, ar_t, role, dir, disp;
	logic [2:0] calm;
	assign aw_t = s_axi_awvalid && s_axi_awready;
	assign w_t = s_axi_wvalid && s_axi_wready;
	assign ar_t = s_axi_arvalid && s_axi_arready;
	// Shadow of the control bits; calm counts quiet cycles after a write,
	// so pin roles are judged only once the output flops have caught up
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{disp, dir, role} <= 3'h0;
			calm <= 3'h0;
		end else if (aw_t && w_t && s_axi_awaddr == `LCD_OFS_CTRL
			&& s_axi_wstrb[0]) begin
			{disp, dir, role} <= {s_axi_wdata[3:2], s_axi_wdata[0]};
			calm <= 3'h0;
		end else if (calm != 3'h7) begin
			calm <= calm + 3'h1;
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Bus handshakes
	// Commit waits one cycle for the held halves, so bvalid shows two on
	wr_answer_a: assert property (aw_t && w_t |-> ##2 s_axi_bvalid)
		else $error("write answer missing");
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
	rd_answer_a: assert property (ar_t |=> s_axi_rvalid)
		else $error("read answer missing");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
	rd_decerr_a: assert property (ar_t && s_axi_araddr > 8'h1C
		|=> s_axi_rresp == `LCD_RESP_DECERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read answered");
	wr_slverr_a: assert property (aw_t && w_t
		&& s_axi_awaddr == `LCD_OFS_STATUS
		|-> ##2 s_axi_bresp == `LCD_RESP_SLVERR)
		else $error("read-only write accepted");
	// Pin roles and output forcing
	seg_pins_a: assert property (
		calm == 3'h7 && !role |-> left_cascade_enable_oe == !dir
		&& right_cascade_enable_oe == dir && !data_pin_left_oe
		&& !data_pin_right_oe) else $error("segment pin roles wrong");
	com_pins_a: assert property (
		calm == 3'h7 && role |-> !left_cascade_enable_oe
		&& !right_cascade_enable_oe && data_pin_right_oe == !dir
		&& data_pin_left_oe == dir) else $error("common pin roles wrong");
	disp_off_a: assert property (
		calm == 3'h7 && !disp |-> drive_outputs == '0)
		else $error("outputs not forced to top");
	cover property (ar_t && s_axi_araddr > 8'h1C);
	cover property (calm == 3'h7 && role && disp);
	cover property (calm == 3'h7 && !role && dir);
endmodule

bind lcd_drv_core lcd_drv_core_asserts lcd_drv_core_asserts_inst (
	.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.data_pin_left_oe, .data_pin_right_oe, .left_cascade_enable_oe,
	.right_cascade_enable_oe, .drive_outputs);

// File: test/tb_lcd_com_seg_driver_logic.sv
// Self-checking bench of the LCD com/seg driver core.
// Assumes the core, its bound checker and the timing controller model.
`timescale 1ns/10ps
`include "lcd_drv_regs.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module tb_lcd_com_seg_driver_logic;
	logic aclk, aresetn = 1'b0, alternation = 1'b0, lce_in = 1'b0;
	logic rce_in = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hF, pd;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, line_latch_clock, data_shift_clock, data_pin_left_o;
	logic data_pin_left_oe, data_pin_right_o, data_pin_right_oe;
	logic left_cascade_enable_o, left_cascade_enable_oe;
	logic right_cascade_enable_o, right_cascade_enable_oe;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [159:0] drive_outputs;
	// Rows: role, alternation, latched bit, expected level code
	logic [4:0] rows [8] = '{5'h04, 5'h01, 5'h0A, 5'h0F, 5'h17, 5'h11,
		5'h1A, 5'h1C};
	int n_errors = 0, num_checks = 0, ch;
	// Two-way pins resolve to whichever side drives them
	wire logic data_pin_first = pd[0];
	wire logic data_pin_middle = pd[2];
	wire logic data_pin_left_i = data_pin_left_oe ? data_pin_left_o : pd[1];
	wire logic data_pin_right_i = data_pin_right_oe ? data_pin_right_o : pd[3];
	wire logic left_cascade_enable_i = left_cascade_enable_oe ?
		left_cascade_enable_o : lce_in;
	wire logic right_cascade_enable_i = right_cascade_enable_oe ?
		right_cascade_enable_o : rce_in;
	lcd_drv_core lcd_drv_core_inst (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.line_latch_clock, .data_shift_clock, .alternation, .data_pin_first,
		.data_pin_left_i, .data_pin_left_o, .data_pin_left_oe,
		.data_pin_middle, .data_pin_right_i, .data_pin_right_o,
		.data_pin_right_oe, .left_cascade_enable_i, .left_cascade_enable_o,
		.left_cascade_enable_oe, .right_cascade_enable_i,
		.right_cascade_enable_o, .right_cascade_enable_oe, .drive_outputs);
	lcd_ctrl_model lcd_ctrl_model_inst (.line_latch_clock,
		.data_shift_clock, .pd);
	// Verdict and end of run
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Register write; address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		repeat (40) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				return;
			end
		end
		n_errors++;
		end_of_test();
	endtask
	// Register read
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		repeat (40) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				return;
			end
		end
		n_errors++;
		end_of_test();
	endtask
	// Pin pulses; the wait covers synchroniser and output flop latency
	task automatic sh(input logic [3:0] v, input int n);
		repeat (n) lcd_ctrl_model_inst.pulse(1'b0, v);
		repeat (8) @(posedge aclk);
	endtask
	task automatic ln(input logic [3:0] v);
		lcd_ctrl_model_inst.pulse(1'b1, v);
		repeat (8) @(posedge aclk);
	endtask
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// Main sequence
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		`CHK(drive_outputs, 160'h0)
		rd(`LCD_OFS_CTRL);
		`CHK(d, 32'h0000_0000)
		rd(8'h20);
		`CHK(r, `LCD_RESP_DECERR)
		wr(`LCD_OFS_STATUS, 32'hFFFF_FFFF);
		`CHK(r, `LCD_RESP_SLVERR)
		// Segment parallel; pulses while the cascade input is high are lost
		wr(`LCD_OFS_CTRL, 32'h0000_0008);
		sh(4'hF, 1);
		rd(`LCD_OFS_STATUS);
		`CHK(d[14:8], 7'h00)
		rce_in <= 1'b0;
		sh(4'h9, 1);
		sh(4'h0, 18);
		`CHK(left_cascade_enable_o, 1'b1)
		sh(4'h0, 1);
		`CHK(left_cascade_enable_o, 1'b0)
		rd(`LCD_OFS_STATUS);
		`CHK(d[14:8], `LCD_PARALLEL_PULSES)
		sh(4'hF, 1);
		ln(4'h0);
		`CHK(left_cascade_enable_o, 1'b1)
		rd(`LCD_OFS_LINE2);
		`CHK(d, 32'h0000_9000)
		// Level table: segment rows, then common single chain rows
		for (int i = 0; i < 8; i++) begin
			if (i == 4) begin
				wr(`LCD_OFS_CTRL, 32'h0000_0009);
				sh(4'hF, 1);
				ln(4'h2);
				rd(`LCD_OFS_LINE0);
				`CHK(d, 32'h0000_0001)
			end
			@(posedge aclk);
			alternation <= rows[i][3];
			repeat (8) @(posedge aclk);
			ch = rows[i][2] ? (rows[i][4] ? 0 : 76) : 1;
			`CHK(drive_outputs[2*ch +: 2], rows[i][1:0])
		end
		// The scan bit reaches the far pin after exactly 79 more pulses
		for (int k = 0; k < 79; k++) begin
			if (k == 78) `CHK(data_pin_right_o, 1'b0)
			ln(4'h0);
		end
		`CHK(data_pin_right_o, 1'b1)
		wr(`LCD_OFS_CTRL, 32'h0000_000B);
		ln(4'h6);
		rd(`LCD_OFS_LINE1);
		`CHK(d, 32'h0000_0100)
		// Dual, right to left: right pin feeds bit 79, left pin shows bit 0
		wr(`LCD_OFS_CTRL, 32'h0000_000F);
		`CHK(data_pin_left_o, 1'b1)
		ln(4'h8);
		rd(`LCD_OFS_LINE2);
		`CHK(d, 32'h0000_8000)
		`CHK(data_pin_left_o, 1'b0)
		// Serial, right to left; the tied-high pins must not leak in
		wr(`LCD_OFS_CTRL, 32'h0000_000E);
		sh(4'hF, 1);
		sh(4'hE, 1);
		sh(4'hF, 77);
		`CHK(right_cascade_enable_o, 1'b1)
		sh(4'hF, 1);
		`CHK(right_cascade_enable_o, 1'b0)
		rd(`LCD_OFS_STATUS);
		`CHK(d[14:8], `LCD_SERIAL_PULSES)
		ln(4'hE);
		rd(`LCD_OFS_LINE0);
		`CHK(d[1:0], 2'b01)
		alternation <= 1'b1;
		wr(`LCD_OFS_CTRL, 32'h0000_0001);
		repeat (8) @(posedge aclk);
		`CHK(drive_outputs, 160'h0)
		end_of_test();
	end
endmodule
